// >>> rtl/txabort_pkg.sv
// Package for the transmit-buffer reservation and abort control block.
// Assumes a single 40 MHz clock domain and a CAN bit tick from the bit timing logic.
package txabort_pkg;

  // Number of message buffers and index of the last data byte.
  localparam int NUM_BUF = 3;
  localparam int BUF_W = 2;
  localparam logic [2:0] LAST_DATA_BYTE = 3'h7;

  // Preparation window before start of frame, in bit times.
  localparam int PREP_BITS = 2;
  localparam logic [1:0] PREP_CNT = 2'(PREP_BITS);
  // Recessive gap after an attempt ends before a new start of frame, in bit times.
  localparam int GAP_BITS = 3;
  localparam logic [1:0] GAP_CNT = 2'(GAP_BITS);
  // Counter value at the tick that closes the preparation window or the gap.
  localparam logic [1:0] CNT_LAST = 2'h1;
  // Attempt outcome encoding from the frame engine.
  typedef enum logic [1:0] {OUT_NONE, OUT_OK, OUT_ERROR, OUT_ARB_LOST} outcome_t;

  // Per-buffer status seen by software.
  typedef struct packed {
    logic lock;
    logic ready;
    logic busy;
  } buffer_ctrl_status_t;

  // Controller control and status bits.
  typedef struct packed {
    logic run;
    logic abort_sync_bit;
    logic no_auto_retransmit;
  } controller_ctrl_status_t;

  // Frame engine hand-off for one attempt.
  typedef struct packed {
    logic start;
    logic [BUF_W-1:0] buf_idx;
  } tx_start_t;

endpackage : txabort_pkg

// >>> rtl/tx_abort_ctrl.sv
// Transmit-buffer reservation, request and abort control for a CAN controller.
// Software bits arrive as same-clock pulses; bit_tick and attempt outcomes come from the
// frame engine on the same clock. The frame engine starts a frame when tx_start pulses.
// Every status output lags the internal flag behind it by one clock.
//
// Summary of operation
// - After reset every buffer is unlocked, so every buffer receives.
// - A locked buffer accepts no received frames and stays reserved for sending.
// - Writing data byte seven of a locked buffer raises request and pending flag.
// - Unlocking a pending buffer not on the bus cancels the request at once.
// - A frame on the bus is finished; software unlocks again afterwards to cancel.
// - The lock cannot be cleared while busy is set, until the frame ends.
// - Setting the abort sync bit drives no dominant pulse onto the transmit line.
// - The abort sync bit reads set within three bit times of its write.
// - While abort sync is set no new transmission starts; software clears it later.
// - Clearing run finishes the current attempt, then enters standby with run zero.
// - In standby unlocking drops pending requests without any bus activity.
// - With no automatic retransmission, an errored attempt is given up, not retried.
// - No automatic retransmission does not cancel a request that lost arbitration.
// - After busy falls enough time passes for an unlock before the next window.
// - A successful send clears pending and busy, emptying the buffer.
// - With no retransmission set, an errored attempt ends clearing pending and busy.
// - Unlocking after lost arbitration aborts at once, clearing pending and lock.
// - No abort interrupt; software polls pending, which clears on abort or success.

`timescale 1ns/1ps

module tx_abort_ctrl (
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Software control strobes.
  input wire logic lock_set,
  input wire logic lock_clr,
  input wire logic [txabort_pkg::BUF_W-1:0] buf_sel,
  input wire logic data_wr,
  input wire logic [2:0] data_byte_idx,
  input wire logic run_wr,
  input wire logic run_val,
  input wire logic sync_wr,
  input wire logic sync_val,
  input wire logic no_auto_retransmit_wr,
  input wire logic no_auto_retransmit_val,
  // Frame engine.
  input wire logic bit_tick,
  input wire txabort_pkg::outcome_t attempt_end,
  // Status to software and the frame engine.
  output txabort_pkg::buffer_ctrl_status_t [txabort_pkg::NUM_BUF-1:0] buffer_ctrl_status,
  output txabort_pkg::controller_ctrl_status_t controller_ctrl_status,
  output logic [txabort_pkg::NUM_BUF-1:0] rx_enable,
  output txabort_pkg::tx_start_t tx_start,
  output logic tx_dominant_req
);

  typedef enum {ST_IDLE, ST_GAP, ST_PREP, ST_ACTIVE, ST_STANDBY} tx_state_t;

  tx_state_t state_r;
  logic [txabort_pkg::NUM_BUF-1:0] lock_r;
  logic [txabort_pkg::NUM_BUF-1:0] ready_r;
  logic [txabort_pkg::NUM_BUF-1:0] busy_r;
  logic [txabort_pkg::BUF_W-1:0] cur_r;
  logic [1:0] cnt_r;
  logic run_r;
  logic run_req_r;
  logic sync_req_r;
  logic sync_r;
  logic no_auto_retransmit_r;
  logic any_pending;
  logic [txabort_pkg::BUF_W-1:0] pick;
  logic pick_ok;
  // Per-buffer decoded strobes and the shared sequencer timing.
  logic [txabort_pkg::NUM_BUF-1:0] set_hit;
  logic [txabort_pkg::NUM_BUF-1:0] clr_ok;
  logic [txabort_pkg::NUM_BUF-1:0] last_byte_hit;
  logic [txabort_pkg::NUM_BUF-1:0] cur_hit;
  logic last_tick;
  logic start_now;

  // Lowest numbered locked, pending buffer wins the next attempt.
  function automatic logic [txabort_pkg::BUF_W-1:0] first_set(
      input logic [txabort_pkg::NUM_BUF-1:0] v);
    logic [txabort_pkg::BUF_W-1:0] r;
    r = '0;
    for (int i = txabort_pkg::NUM_BUF - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = txabort_pkg::BUF_W'(i);
      end
    end
    return r;
  endfunction : first_set

  // One-hot decode of a buffer index, shared by every per-buffer strobe and by the
  // sequencer, so all of them agree on which buffer an index means.
  function automatic logic [txabort_pkg::NUM_BUF-1:0] buf_onehot(
      input logic [txabort_pkg::BUF_W-1:0] idx);
    logic [txabort_pkg::NUM_BUF-1:0] r;
    r = '0;
    for (int i = 0; i < txabort_pkg::NUM_BUF; i++) begin
      if (idx == txabort_pkg::BUF_W'(i)) begin
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction : buf_onehot

  // Per-buffer strobes. A lock clear on a busy buffer is dropped here, so a frame on
  // the bus is never cut short; software has to clear again once busy has fallen.
  always_comb begin
    set_hit = lock_set ? buf_onehot(buf_sel) : '0;
    clr_ok = lock_clr ? (buf_onehot(buf_sel) & ~busy_r) : '0;
    last_byte_hit = '0;
    if (data_wr && data_byte_idx == txabort_pkg::LAST_DATA_BYTE) begin
      last_byte_hit = buf_onehot(buf_sel) & lock_r;
    end
    cur_hit = buf_onehot(cur_r);
  end

  // Sequencer timing. The start decision is made once here so that the busy flag and
  // the start pulse to the frame engine can never disagree about an attempt.
  always_comb begin
    last_tick = bit_tick && cnt_r == txabort_pkg::CNT_LAST;
    start_now = state_r == ST_PREP && last_tick && ready_r[cur_r] && lock_r[cur_r];
  end

  // Candidate selection for the next attempt.
  always_comb begin
    any_pending = |(ready_r & lock_r);
    pick = first_set(ready_r & lock_r);
    // A pending stop also blocks a start, so run can never fall while an attempt begins.
    pick_ok = any_pending && run_r && run_req_r && !sync_r && !sync_req_r;
  end

  // Lock bits per buffer; all clear after reset so every buffer receives.
  // A set and a clear in the same cycle leave the buffer locked; reserving wins.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_r <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < txabort_pkg::NUM_BUF; i++) begin
        if (set_hit[i]) begin
          lock_r[i] <= 1'b1;
        end else if (clr_ok[i]) begin
          lock_r[i] <= 1'b0;
        end
      end
    end
  end

  // Pending flags: set by the last data byte, cleared by abort, success or given-up error.
  // Dropping the lock drops the request too, which is how every abort path ends.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ready_r <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < txabort_pkg::NUM_BUF; i++) begin
        if (last_byte_hit[i]) begin
          ready_r[i] <= 1'b1;
        end else if (!lock_r[i] || clr_ok[i]) begin
          ready_r[i] <= 1'b0;
        end else if (busy_r[i] && cur_hit[i]) begin
          if (attempt_end == txabort_pkg::OUT_OK) begin
            ready_r[i] <= 1'b0;
          end else if (attempt_end == txabort_pkg::OUT_ERROR && no_auto_retransmit_r) begin
            ready_r[i] <= 1'b0;
          end
        end
      end
    end
  end

  // Busy follows the attempt on the bus; it falls at the end of every attempt.
  // It rises with the start pulse, so software never sees busy without a frame.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_r <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < txabort_pkg::NUM_BUF; i++) begin
        if (start_now && cur_hit[i]) begin
          busy_r[i] <= 1'b1;
        end else if (attempt_end != txabort_pkg::OUT_NONE && state_r == ST_ACTIVE) begin
          busy_r[i] <= 1'b0;
        end
      end
    end
  end

  // Attempt sequencer: gap after each attempt, two-bit preparation, then the frame.
  // The gap gives an unlock issued after busy falls time to land before the next window.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_STANDBY;
      cnt_r <= '0;
      cur_r <= '0;
    end else if (clk_en) begin
      case (state_r)
        ST_STANDBY: begin
          if (run_r) begin
            state_r <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (!run_r) begin
            state_r <= ST_STANDBY;
          end else if (pick_ok) begin
            cur_r <= pick;
            cnt_r <= txabort_pkg::PREP_CNT;
            state_r <= ST_PREP;
          end
        end
        ST_PREP: begin
          if (!ready_r[cur_r] || !lock_r[cur_r]) begin
            state_r <= ST_IDLE;
          end else if (bit_tick) begin
            if (last_tick) begin
              state_r <= ST_ACTIVE;
            end else begin
              cnt_r <= cnt_r - txabort_pkg::CNT_LAST;
            end
          end
        end
        ST_ACTIVE: begin
          if (attempt_end != txabort_pkg::OUT_NONE) begin
            cnt_r <= txabort_pkg::GAP_CNT;
            state_r <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (!run_r) begin
            state_r <= ST_STANDBY;
          end else if (bit_tick) begin
            if (last_tick) begin
              state_r <= ST_IDLE;
            end else begin
              cnt_r <= cnt_r - txabort_pkg::CNT_LAST;
            end
          end
        end
        default: begin
          state_r <= ST_STANDBY;
        end
      endcase
    end
  end

  // Run bit: a stop request reads one until the current attempt has finished.
  // Dropping run during preparation still lets that attempt out; it counts as current.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_req_r <= 1'b0;
      run_r <= 1'b0;
    end else if (clk_en) begin
      if (run_wr) begin
        run_req_r <= run_val;
      end
      if (run_wr && run_val) begin
        run_r <= 1'b1;
      end else if (!run_req_r && state_r != ST_ACTIVE && state_r != ST_PREP) begin
        run_r <= 1'b0;
      end
    end
  end

  // Abort sync: the request is acknowledged only outside the preparation window.
  // Preparation is at most two bit ticks long, so the acknowledge lands within three bit times.
  // A write of zero wins over a pending acknowledge, so transmitting resumes at once.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_req_r <= 1'b0;
      sync_r <= 1'b0;
    end else if (clk_en) begin
      if (sync_wr) begin
        sync_req_r <= sync_val;
      end
      if (sync_wr && !sync_val) begin
        sync_r <= 1'b0;
      end else if (sync_req_r && state_r != ST_PREP) begin
        sync_r <= 1'b1;
      end
    end
  end

  // No automatic retransmission bit, written directly by software.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      no_auto_retransmit_r <= 1'b0;
    end else if (clk_en && no_auto_retransmit_wr) begin
      no_auto_retransmit_r <= no_auto_retransmit_val;
    end
  end

  // Buffer status to software, one clock behind the internal flags.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buffer_ctrl_status <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < txabort_pkg::NUM_BUF; i++) begin
        buffer_ctrl_status[i] <= '{lock: lock_r[i], ready: ready_r[i], busy: busy_r[i]};
      end
    end
  end

  // Controller status to software; run reads one until a stop has taken effect.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      controller_ctrl_status <= '0;
    end else if (clk_en) begin
      controller_ctrl_status <= '{run: run_r, abort_sync_bit: sync_r, no_auto_retransmit: no_auto_retransmit_r};
    end
  end

  // Receive enables: every buffer receives out of reset, a lock withdraws it.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_enable <= '1;
    end else if (clk_en) begin
      rx_enable <= ~lock_r;
    end
  end

  // Start pulse to the frame engine; it lasts one clock because start_now does.
  // The buffer index is held from the pulse until the next pick so the engine may sample it late.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_start <= '0;
    end else if (clk_en) begin
      tx_start <= '{start: start_now, buf_idx: cur_r};
    end
  end

  // The transmit line is never pulled dominant from here. The abort sync bit only
  // orders a lock clear against the internal request and sends no wake-up pulse.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_dominant_req <= 1'b0;
    end else if (clk_en) begin
      tx_dominant_req <= 1'b0;
    end
  end

endmodule : tx_abort_ctrl

// >>> sim/frame_peer.sv
// Frame engine stand-in: free bit ticks and one outcome per attempt.
// Assumes the controller pulses tx_start once per attempt on the same clock.
`timescale 1ns/1ps
module frame_peer (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Attempt start and the outcome the bench commands.
  input wire txabort_pkg::tx_start_t tx_start,
  input wire txabort_pkg::outcome_t res,
  // Answers to the controller.
  output logic bit_tick,
  output txabort_pkg::outcome_t attempt_end
);
  logic [1:0] div_r;
  logic [2:0] bits_r;
  logic on_r;
  // Bit time is four clocks, short enough to keep the run brief.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_r <= 2'h0;
      bit_tick <= 1'b0;
    end else begin
      div_r <= div_r + 2'h1;
      bit_tick <= (div_r == 2'h3);
    end
  end
  // An attempt always runs its full six bits before the outcome is reported.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      on_r <= 1'b0;
      bits_r <= 3'h0;
      attempt_end <= txabort_pkg::OUT_NONE;
    end else begin
      attempt_end <= txabort_pkg::OUT_NONE;
      if (tx_start.start) begin
        on_r <= 1'b1;
        bits_r <= 3'h0;
      end else if (on_r && bit_tick) begin
        bits_r <= bits_r + 3'h1;
        if (bits_r == 3'h5) begin
          on_r <= 1'b0;
          attempt_end <= res;
        end
      end
    end
  end
endmodule : frame_peer

// >>> sim/tx_abort_ctrl_properties.sv
// Concurrent checks on the abort control ports, bound into the design.
// Assumes the bench keeps clk_en high and bit ticks every four clocks.
`timescale 1ns/1ps
module tx_abort_ctrl_properties (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Software strobes and outcomes.
  input wire logic clk_en,
  input wire logic lock_clr,
  input wire logic [txabort_pkg::BUF_W-1:0] buf_sel,
  input wire logic data_wr,
  input wire logic [2:0] data_byte_idx,
  input wire logic sync_wr,
  input wire logic sync_val,
  input wire txabort_pkg::outcome_t attempt_end,
  // Status outputs.
  input wire txabort_pkg::buffer_ctrl_status_t [txabort_pkg::NUM_BUF-1:0] buffer_ctrl_status,
  input wire txabort_pkg::controller_ctrl_status_t controller_ctrl_status,
  input wire txabort_pkg::tx_start_t tx_start,
  input wire logic tx_dominant_req
);
  // Only buffer 0 is checked here, so its flags get short names.
  wire logic lk = buffer_ctrl_status[0].lock;
  wire logic rd = buffer_ctrl_status[0].ready;
  wire logic bz = buffer_ctrl_status[0].busy;
  wire logic hit0 = clk_en && buf_sel == 2'h0;
  wire logic syn = controller_ctrl_status.abort_sync_bit;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_tx_line_quiet: assert property (!tx_dominant_req)
    else $error("dominant request seen");
  a_sync_blocks_start: assert property (syn |-> !tx_start.start)
    else $error("start while abort sync set");
  a_standby_no_start: assert property (!controller_ctrl_status.run |-> !tx_start.start)
    else $error("start in standby");
  a_lock_held_busy: assert property (bz && $past(bz) && $past(lk) |-> lk)
    else $error("lock cleared while busy");
  a_sync_reads_set: assert property (sync_wr && sync_val && clk_en && !syn |-> ##[1:14] syn)
    else $error("abort sync not set in time");
  a_request_on_byte7: assert property (data_wr && data_byte_idx == 3'h7 && hit0 && lk && !lock_clr |-> ##2 rd)
    else $error("byte seven raised no request");
  a_ok_empties: assert property (bz && attempt_end == txabort_pkg::OUT_OK |-> ##2 !rd && !bz)
    else $error("buffer not empty after success");
  a_error_gives_up: assert property (bz && attempt_end == txabort_pkg::OUT_ERROR &&
      controller_ctrl_status.no_auto_retransmit |-> ##2 !rd && !bz)
    else $error("errored attempt retried");
  a_arb_keeps: assert property (bz && attempt_end == txabort_pkg::OUT_ARB_LOST |-> ##2 rd && !bz)
    else $error("lost request dropped");
  a_unlock_aborts: assert property (rd && lk && !bz && !tx_start.start && lock_clr && hit0 |-> ##2 !rd && !lk)
    else $error("unlock did not abort");
  c_start: cover property (tx_start.start);
  c_arb_lost: cover property (attempt_end == txabort_pkg::OUT_ARB_LOST);
  c_sync_set: cover property (syn);
endmodule : tx_abort_ctrl_properties
bind tx_abort_ctrl tx_abort_ctrl_properties u_tx_abort_ctrl_properties (.clk, .rstn, .clk_en, .lock_clr, .buf_sel,
  .data_wr, .data_byte_idx, .sync_wr, .sync_val, .attempt_end, .buffer_ctrl_status, .controller_ctrl_status,
  .tx_start, .tx_dominant_req);

// >>> sim/tx_abort_ctrl_tb.sv
// Self-checking bench for the abort control block.
// Drives strobes at the falling edge; frame_peer answers each attempt.
`timescale 1ns/1ps
module tx_abort_ctrl_tb;
  logic clk, rstn, clk_en, lock_set, lock_clr, data_wr, run_wr, run_val;
  logic sync_wr, sync_val, no_auto_retransmit_wr, no_auto_retransmit_val, bit_tick, tx_dominant_req;
  logic [1:0] buf_sel;
  logic [2:0] data_byte_idx;
  logic [2:0] rx_enable;
  txabort_pkg::outcome_t attempt_end, res;
  txabort_pkg::buffer_ctrl_status_t [2:0] bcs;
  txabort_pkg::controller_ctrl_status_t ccs;
  txabort_pkg::tx_start_t tx_start;
  int bad_count, compares;
  int starts, s0;
  tx_abort_ctrl u_tx_abort_ctrl (.clk, .rstn, .clk_en, .lock_set, .lock_clr, .buf_sel, .data_wr, .data_byte_idx,
    .run_wr, .run_val, .sync_wr, .sync_val, .no_auto_retransmit_wr, .no_auto_retransmit_val, .bit_tick, .attempt_end,
    .buffer_ctrl_status(bcs), .controller_ctrl_status(ccs), .rx_enable, .tx_start, .tx_dominant_req);
  frame_peer u_frame_peer (.clk, .rstn, .tx_start, .res, .bit_tick, .attempt_end);
  // Counts start pulses so quiet phases can be checked for stray frames.
  always @(posedge clk) begin
    if (tx_start.start) begin
      starts++;
    end
  end
  // 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task close_out;
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task check(input logic [2:0] seen, input logic [2:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask : check
  // One strobe cycle, then two cycles for the registered status to settle.
  task buf_op(input logic s, input logic c, input logic w, input logic [1:0] b);
    lock_set = s;
    lock_clr = c;
    data_wr = w;
    buf_sel = b;
    @(negedge clk);
    lock_set = 1'b0;
    lock_clr = 1'b0;
    data_wr = 1'b0;
    repeat (2) @(negedge clk);
  endtask : buf_op
  // Controller write: 0 run, 1 abort sync, 2 no retransmission.
  task ctl(input int k, input logic v);
    run_wr = (k == 0);
    sync_wr = (k == 1);
    no_auto_retransmit_wr = (k == 2);
    {run_val, sync_val, no_auto_retransmit_val} = {3{v}};
    @(negedge clk);
    {run_wr, sync_wr, no_auto_retransmit_wr} = 3'h0;
    repeat (2) @(negedge clk);
  endtask : ctl
  // Bounded poll, since a stuck flag would otherwise hang the run.
  task wait_for(input int sel, input logic val);
    int n;
    n = 0;
    while ((sel == 0 ? bcs[0].busy : sel == 1 ? ccs.abort_sync_bit : ccs.run) !== val && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n == 200) begin
      bad_count++;
      $display("[ERR] %0t wait timed out", $time);
      close_out();
    end
  endtask : wait_for
  initial begin
    {rstn, clk_en, lock_set, lock_clr, data_wr, run_wr, run_val, sync_wr, sync_val, no_auto_retransmit_wr, no_auto_retransmit_val} = '0;
    buf_sel = 2'h0;
    data_byte_idx = 3'h6;
    res = txabort_pkg::OUT_OK;
    bad_count = 0;
    compares = 0;
    starts = 0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    clk_en = 1'b1;
    check(rx_enable, 3'h7);
    check(bcs[0], 3'h0);
    ctl(0, 1'b1);
    // Lock stops reception; byte six alone requests nothing.
    buf_op(1'b1, 1'b0, 1'b0, 2'h0);
    buf_op(1'b0, 1'b0, 1'b1, 2'h0);
    check(rx_enable, 3'h6);
    check(bcs[0], 3'h4);
    data_byte_idx = 3'h7;
    buf_op(1'b0, 1'b0, 1'b1, 2'h1);
    check(bcs[1], 3'h0);
    // Success, with an unlock during the frame that must be ignored.
    buf_op(1'b0, 1'b0, 1'b1, 2'h0);
    wait_for(0, 1'b1);
    buf_op(1'b0, 1'b1, 1'b0, 2'h0);
    check(bcs[0], 3'h7);
    wait_for(0, 1'b0);
    check(bcs[0], 3'h4);
    // Error with retransmission off, then lost arbitration.
    ctl(2, 1'b1);
    check({2'h0, ccs.no_auto_retransmit}, 3'h1);
    res = txabort_pkg::OUT_ERROR;
    buf_op(1'b0, 1'b0, 1'b1, 2'h0);
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    check(bcs[0], 3'h4);
    res = txabort_pkg::OUT_ARB_LOST;
    buf_op(1'b0, 1'b0, 1'b1, 2'h0);
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    check(bcs[0], 3'h6);
    buf_op(1'b0, 1'b1, 1'b0, 2'h0);
    check(bcs[0], 3'h0);
    ctl(2, 1'b0);
    // Abort sync holds off the start, then an unlock cancels.
    ctl(1, 1'b1);
    wait_for(1, 1'b1);
    check({2'h0, tx_dominant_req}, 3'h0);
    s0 = starts;
    buf_op(1'b1, 1'b0, 1'b0, 2'h0);
    buf_op(1'b0, 1'b0, 1'b1, 2'h0);
    repeat (40) @(negedge clk);
    check(bcs[0], 3'h6);
    check({2'h0, starts == s0}, 3'h1);
    buf_op(1'b0, 1'b1, 1'b0, 2'h0);
    check(bcs[0], 3'h0);
    ctl(1, 1'b0);
    // Standby waits for the attempt, then unlocking drops the request.
    res = txabort_pkg::OUT_ERROR;
    buf_op(1'b1, 1'b0, 1'b0, 2'h0);
    buf_op(1'b0, 1'b0, 1'b1, 2'h0);
    wait_for(0, 1'b1);
    ctl(0, 1'b0);
    check({2'h0, ccs.run}, 3'h1);
    wait_for(2, 1'b0);
    @(negedge clk);
    s0 = starts;
    check(bcs[0], 3'h6);
    buf_op(1'b0, 1'b1, 1'b0, 2'h0);
    repeat (40) @(negedge clk);
    check(bcs[0], 3'h0);
    check({2'h0, starts == s0}, 3'h1);
    close_out();
  end
endmodule : tx_abort_ctrl_tb
